// *** verilog/dnc_pkg.sv ***
/*
 shared constants and types of the down-conversion path: register map, control fields,
 reset values, arithmetic widths, oscillator table and the stream carriers.
 assumes one sampling clock and the plain register port of the top module.
*/
package dnc_pkg;
   localparam int DNC_SMP_W = 16;
   localparam int DNC_ACC_W = 20;
   localparam int DNC_NCO_W = 32;
   localparam int DNC_LUT_W = 12;

   // register byte addresses
   localparam logic [7:0] DNC_REG_CTRL = 8'h00;
   localparam logic [7:0] DNC_REG_FREQ = 8'h04;
   localparam logic [7:0] DNC_REG_ACTV = 8'h08;
   localparam logic [7:0] DNC_REG_STAT = 8'h0C;

   // control register fields
   localparam int CTL_EN = 0;
   localparam int CTL_REAL = 1;
   localparam int CTL_QRM = 2;
   localparam int CTL_DEC = 3;
   localparam int CTL_G6 = 6;
   localparam int CTL_G3 = 7;
   localparam int CTL_INV = 8;
   localparam int CTL_SWAP = 9;
   localparam int CTL_RES = 10;
   localparam int CTL_RESTART = 13;
   localparam int CTL_SYNC_EN = 14;
   localparam logic [31:0] DNC_CTRL_MASK = 32'h0000_7FFF;
   localparam logic [31:0] DNC_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] DNC_FREQ_RST = 32'h0000_0000;

   // decimation code 0..4 selects 2..32; resolution code 0..6 selects 14..20 bits
   localparam logic [2:0] DNC_DEC_TOP = 3'h4;
   localparam logic [2:0] DNC_RES_TOP = 3'h6;
   localparam logic [5:0] DNC_QTR_TURN = 6'h10;
   localparam int DNC_MIX_SHIFT = 7;
   localparam logic signed [28:0] DNC_G3_MUL = 29'sh00000B5;
   localparam int DNC_G3_SHIFT = 7;
   localparam logic signed [28:0] DNC_SAT_HI = 29'sh007FFFF;
   localparam logic signed [28:0] DNC_SAT_LO = 29'sh1FF80000;
   localparam logic [19:0] DNC_MOST_NEG = 20'h80000;
   localparam logic [19:0] DNC_MOST_POS = 20'h7FFFF;

   // first quarter of a cosine, 17 points, full scale 2047
   localparam logic [11:0] DNC_COS_TAB [0:16] = '{
      12'h7FF, 12'h7F5, 12'h7D8, 12'h7A7, 12'h763, 12'h70D, 12'h6A6, 12'h62E, 12'h5A7,
      12'h513, 12'h471, 12'h3C5, 12'h30F, 12'h252, 12'h18F, 12'h0C9, 12'h000};

   typedef struct packed {
      logic [15:0] a;
      logic [15:0] b;
   } dnc_pair_t;

   typedef struct packed {
      logic [19:0] i;
      logic [19:0] q;
   } dnc_cplx_t;

   typedef enum logic [1:0] {KIND_RAW, KIND_REAL, KIND_I, KIND_Q} dnc_kind_t;

   typedef struct packed {
      dnc_kind_t kind;
      logic [19:0] a;
      logic [19:0] b;
   } dnc_word_t;
endpackage

// *** verilog/dnc_lane.sv ***
/*
 one decimating low-pass lane: accumulate-and-dump average of 2^shift complex samples.
 assumes the caller stalls it with en and clears it on a synchronisation event.
*/
`timescale 1ns/10ps
module dnc_lane
   import dnc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // control
   input wire logic en,
   input wire logic clr,
   input wire logic [2:0] shift,
   // mixed samples
   input wire logic in_v,
   input wire dnc_cplx_t in_s,
   // decimated result
   output logic out_v,
   output dnc_cplx_t out_s
);
   logic [5:0] cnt_q;
   dnc_cplx_t acc_q;
   logic out_v_q;
   dnc_cplx_t out_s_q;
   logic [5:0] last;
   logic first;
   logic dump;
   logic signed [19:0] sum_i;
   logic signed [19:0] sum_q;

   assign last = (6'h01 << shift) - 6'h01;
   assign first = (cnt_q == 6'h00);
   assign dump = (cnt_q >= last);
   // each term is pre-scaled so the running sum never leaves 20 bits
   assign sum_i = (first ? 20'sh00000 : $signed(acc_q.i)) + ($signed(in_s.i) >>> shift);
   assign sum_q = (first ? 20'sh00000 : $signed(acc_q.q)) + ($signed(in_s.q) >>> shift);
   assign out_v = out_v_q;
   assign out_s = out_s_q;

   always_ff @(posedge ref_clk) begin
      if (rst || clr) begin
         cnt_q <= 6'h00;
         acc_q <= '0;
         out_v_q <= 1'b0;
         out_s_q <= '0;
      end else if (en) begin
         out_v_q <= in_v && dump;
         if (in_v) begin
            cnt_q <= dump ? 6'h00 : cnt_q + 6'h01;
            acc_q <= {sum_i, sum_q};
         end
         if (in_v && dump) begin
            out_s_q <= {sum_i, sum_q};
         end
      end
   end
endmodule

// *** verilog/dnc_top.sv ***
/*
 down-conversion path of a dual-channel converter: register port, channel swap,
 oscillator and mixer, two decimating lanes, gain, truncation and a two-entry
 output buffer.
 assumes samples, sync pin and register strobes are synchronous to ref_clk,
 which is the sampling clock.
*/
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
module dnc_top
   import dnc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // synchronisation pin
   input wire logic sync_in,
   // converter samples
   input wire dnc_pair_t smp_in,
   input wire logic smp_valid,
   output logic smp_ready,
   // output stream to the formatter
   output dnc_word_t out_word,
   output logic out_valid,
   input wire logic out_ready
);
   function automatic logic signed [11:0] cos_lut(input logic [5:0] idx);
      logic [4:0] r;
      logic signed [11:0] m;
      r = idx[4] ? (5'h10 - {1'b0, idx[3:0]}) : {1'b0, idx[3:0]};
      m = $signed(DNC_COS_TAB[r]);
      return (idx[5] ^ idx[4]) ? -m : m;
   endfunction

   function automatic logic [19:0] mix(input logic [15:0] x, input logic signed [11:0] c);
      logic signed [27:0] p;
      p = $signed(x) * c;
      return p[26:DNC_MIX_SHIFT];
   endfunction

   function automatic logic [19:0] neg20(input logic [19:0] v);
      return (v == DNC_MOST_NEG) ? DNC_MOST_POS : 20'(-$signed(v));
   endfunction

   function automatic logic [19:0] fmt(input logic [19:0] v, input logic g6, input logic g3,
                                       input logic [2:0] drop);
      logic signed [28:0] g;
      g = 29'($signed(v));
      if (g6) begin
         g = g <<< 1;
      end else if (g3) begin
         g = (g * DNC_G3_MUL) >>> DNC_G3_SHIFT;
      end
      if (g > DNC_SAT_HI) begin
         g = DNC_SAT_HI;
      end else if (g < DNC_SAT_LO) begin
         g = DNC_SAT_LO;
      end
      return 20'(g >>> drop);
   endfunction

   // registers and control state
   logic [31:0] ctrl_q;
   logic [31:0] freq_q;
   logic [31:0] actv_q;
   logic [31:0] phase_q;
   logic restart_q;
   logic sync_q;
   logic [31:0] rdata_q;
   logic [31:0] rd_mux;
   logic [31:0] stat_w;
   logic wr_ctrl;
   logic wr_freq;

   // control fields
   logic en;
   logic real_m;
   logic cplx;
   logic qrm;
   logic swap;
   logic inv;
   logic g6;
   logic g3;
   logic [2:0] dec_code;
   logic [2:0] res_code;
   logic [2:0] shift;
   logic [2:0] drop;
   logic load_ev;

   // input skid and mixer stage
   logic skid_v_q;
   dnc_pair_t skid_q;
   logic ready_q;
   logic accept;
   logic adv;
   logic take;
   logic src_v;
   dnc_pair_t src;
   logic [15:0] xa;
   logic [15:0] xb;
   logic [5:0] lut_idx;
   logic signed [11:0] cos_w;
   logic signed [11:0] sin_w;
   logic signed [11:0] sin_m;
   dnc_cplx_t ma_d;
   dnc_cplx_t mb_d;
   dnc_cplx_t ma_q;
   dnc_cplx_t mb_q;
   logic m_v_q;

   // lanes and word formation
   logic la_v;
   logic lb_v;
   dnc_cplx_t la_s;
   dnc_cplx_t lb_s;
   logic qpar_q;
   logic [19:0] ia;
   logic [19:0] ib;
   logic [19:0] qa;
   logic [19:0] qb;
   dnc_word_t w0;
   dnc_word_t w1;
   logic two;

   // output buffer
   logic pend_v_q;
   dnc_word_t pend_q;
   logic head_v_q;
   logic tail_v_q;
   dnc_word_t head_q;
   dnc_word_t tail_q;
   logic head_v_d;
   logic tail_v_d;
   dnc_word_t head_d;
   dnc_word_t tail_d;
   logic space;
   logic pop;
   logic push_pend;
   logic push_new;
   logic push;
   dnc_word_t push_w;

   // register decode
   assign wr_ctrl = reg_wr && (reg_addr == DNC_REG_CTRL);
   assign wr_freq = reg_wr && (reg_addr == DNC_REG_FREQ);
   assign stat_w = {26'h0000000, qpar_q, pend_v_q, tail_v_q, head_v_q, skid_v_q, en};
   assign rd_mux = (reg_addr == DNC_REG_CTRL) ? ctrl_q :
                   (reg_addr == DNC_REG_FREQ) ? freq_q :
                   (reg_addr == DNC_REG_ACTV) ? actv_q :
                   (reg_addr == DNC_REG_STAT) ? stat_w : 32'h0000_0000;

   // mode decode
   assign en = ctrl_q[CTL_EN];
   assign real_m = en && ctrl_q[CTL_REAL];
   assign cplx = en && !ctrl_q[CTL_REAL];
   assign qrm = cplx && ctrl_q[CTL_QRM];
   assign swap = ctrl_q[CTL_SWAP];
   assign inv = ctrl_q[CTL_INV];
   assign g6 = cplx && ctrl_q[CTL_G6];
   assign g3 = real_m && ctrl_q[CTL_G3];
   assign dec_code = ctrl_q[CTL_DEC +: 3];
   assign res_code = ctrl_q[CTL_RES +: 3];
   // disabled path decimates by one, so every sample passes
   assign shift = !en ? 3'h0 :
                  (dec_code > DNC_DEC_TOP) ? DNC_DEC_TOP + 3'h1 : dec_code + 3'h1;
   assign drop = (res_code > DNC_RES_TOP) ? 3'h0 : DNC_RES_TOP - res_code;

   // restart bit toggle or rising sync edge loads the pending frequency
   assign load_ev = (ctrl_q[CTL_RESTART] ^ restart_q) ||
                    (ctrl_q[CTL_SYNC_EN] && sync_in && !sync_q);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= DNC_CTRL_RST;
         freq_q <= DNC_FREQ_RST;
         restart_q <= 1'b0;
         sync_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         if (wr_ctrl) begin
            ctrl_q <= reg_wdata & DNC_CTRL_MASK;
         end
         if (wr_freq) begin
            freq_q <= reg_wdata;
         end
         restart_q <= ctrl_q[CTL_RESTART];
         sync_q <= sync_in;
         rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
      end
   end

   // oscillator: phase wraps modulo 2^32, so a signed word spans minus to plus half rate
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         actv_q <= DNC_FREQ_RST;
         phase_q <= 32'h0000_0000;
      end else if (load_ev) begin
         actv_q <= freq_q;
         phase_q <= 32'h0000_0000;
      end else if (take && cplx) begin
         phase_q <= phase_q + actv_q;
      end
   end

   // input skid keeps samples that arrive while the pipeline stalls
   assign accept = smp_valid && ready_q;
   assign src_v = skid_v_q || accept;
   assign src = skid_v_q ? skid_q : smp_in;
   assign take = adv && src_v;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         skid_v_q <= 1'b0;
         skid_q <= '0;
         ready_q <= 1'b0;
      end else begin
         skid_v_q <= !adv && (skid_v_q || accept);
         ready_q <= !(!adv && (skid_v_q || accept));
         if (accept && !adv) begin
            skid_q <= smp_in;
         end
      end
   end

   // channel swap and mixer
   assign xa = swap ? src.b : src.a;
   assign xb = swap ? src.a : src.b;
   assign lut_idx = phase_q[31:26];
   assign cos_w = cos_lut(lut_idx);
   assign sin_w = cos_lut(lut_idx - DNC_QTR_TURN);
   assign sin_m = inv ? -sin_w : sin_w;
   assign ma_d = cplx ? {mix(xa, cos_w), mix(xa, sin_m)} :
                 {xa, 4'h0, 20'h00000};
   assign mb_d = cplx ? {mix(xb, cos_w), mix(xb, sin_m)} : {xb, 4'h0, 20'h00000};

   always_ff @(posedge ref_clk) begin
      if (rst || load_ev) begin
         m_v_q <= 1'b0;
         ma_q <= '0;
         mb_q <= '0;
      end else if (adv) begin
         m_v_q <= src_v;
         ma_q <= ma_d;
         mb_q <= mb_d;
      end
   end

   dnc_lane u_lane_a (
      .ref_clk(ref_clk),
      .rst(rst),
      .en(adv),
      .clr(load_ev),
      .shift(shift),
      .in_v(m_v_q),
      .in_s(ma_q),
      .out_v(la_v),
      .out_s(la_s)
   );

   dnc_lane u_lane_b (
      .ref_clk(ref_clk),
      .rst(rst),
      .en(adv),
      .clr(load_ev),
      .shift(shift),
      .in_v(m_v_q),
      .in_s(mb_q),
      .out_v(lb_v),
      .out_s(lb_s)
   );

   // quarter-rate tone 1, j, -1, -j over two real words per complex result
   assign ia = (qrm && qpar_q) ? neg20(la_s.i) : la_s.i;
   assign ib = (qrm && qpar_q) ? neg20(lb_s.i) : lb_s.i;
   assign qa = (qrm && !qpar_q) ? neg20(la_s.q) : la_s.q;
   assign qb = (qrm && !qpar_q) ? neg20(lb_s.q) : lb_s.q;
   assign two = cplx;

   assign w0.kind = !en ? KIND_RAW : (real_m || qrm) ? KIND_REAL : KIND_I;
   assign w0.a = !en ? 20'($signed(la_s.i) >>> 4) : fmt(ia, g6, g3, drop);
   assign w0.b = !en ? 20'($signed(lb_s.i) >>> 4) : fmt(ib, g6, g3, drop);
   assign w1.kind = qrm ? KIND_REAL : KIND_Q;
   assign w1.a = fmt(qa, g6, g3, drop);
   assign w1.b = fmt(qb, g6, g3, drop);

   // pipeline moves unless a finished word cannot be placed
   assign pop = head_v_q && out_ready;
   assign space = !tail_v_q || pop;
   assign push_pend = pend_v_q && space;
   assign push_new = !pend_v_q && la_v && lb_v && space;
   assign push = push_pend || push_new;
   assign push_w = pend_v_q ? pend_q : w0;
   assign adv = !la_v || push_new;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pend_v_q <= 1'b0;
         pend_q <= '0;
         qpar_q <= 1'b0;
      end else begin
         if (push_new && two) begin
            pend_v_q <= 1'b1;
            pend_q <= w1;
         end else if (push_pend) begin
            pend_v_q <= 1'b0;
         end
         if (load_ev) begin
            qpar_q <= 1'b0;
         end else if (push_new && qrm) begin
            qpar_q <= !qpar_q;
         end
      end
   end

   // two-entry buffer; head is the output register
   always_comb begin
      head_v_d = head_v_q;
      tail_v_d = tail_v_q;
      head_d = head_q;
      tail_d = tail_q;
      if (pop) begin
         head_v_d = tail_v_q;
         head_d = tail_q;
         tail_v_d = 1'b0;
      end
      if (push && !head_v_d) begin
         head_v_d = 1'b1;
         head_d = push_w;
      end else if (push) begin
         tail_v_d = 1'b1;
         tail_d = push_w;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         head_v_q <= 1'b0;
         tail_v_q <= 1'b0;
         head_q <= '0;
         tail_q <= '0;
      end else begin
         head_v_q <= head_v_d;
         tail_v_q <= tail_v_d;
         head_q <= head_d;
         tail_q <= tail_d;
      end
   end

   assign reg_rdata = rdata_q;
   assign smp_ready = ready_q;
   assign out_word = head_q;
   assign out_valid = head_v_q;
endmodule

// *** test/dnc_checker.sv ***
/*
 port checker of the down-conversion path: register answers, reset quiet, stream holding.
 assumes it is bound to dnc_top and sees only its ports.
*/
`timescale 1ns/10ps
module dnc_checker
   import dnc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   // sync and samples
   input wire logic sync_in,
   input wire dnc_pair_t smp_in,
   input wire logic smp_valid,
   input wire logic smp_ready,
   // output stream
   input wire dnc_word_t out_word,
   input wire logic out_valid,
   input wire logic out_ready
);
   logic [31:0] ctrl_q;
   logic [31:0] freq_q;
   logic pair_q;
   wire logic mapped = reg_addr inside {DNC_REG_CTRL, DNC_REG_FREQ, DNC_REG_ACTV, DNC_REG_STAT};
   wire logic take = out_valid && out_ready;
   wire logic ctl_wr = reg_wr && reg_addr == DNC_REG_CTRL;

   // shadows of the writable registers; pair_q allows a Q word after an I word or a reload
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctrl_q <= DNC_CTRL_RST;
         freq_q <= DNC_FREQ_RST;
         pair_q <= 1'b1;
      end else begin
         if (ctl_wr) ctrl_q <= reg_wdata & DNC_CTRL_MASK;
         if (reg_wr && reg_addr == DNC_REG_FREQ) freq_q <= reg_wdata;
         if (ctl_wr || sync_in) pair_q <= 1'b1;
         else if (take) pair_q <= out_word.kind == KIND_I;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
      else $error("read data not zero outside a read answer");
   a_unmapped_read: assert property (reg_rd && !mapped |=> reg_rdata == 32'h0)
      else $error("unmapped read returned data");
   a_ctrl_readback: assert property (reg_rd && reg_addr == DNC_REG_CTRL |=>
      reg_rdata == $past(ctrl_q))
      else $error("control read differs from last write");
   a_freq_readback: assert property (reg_rd && reg_addr == DNC_REG_FREQ |=>
      reg_rdata == $past(freq_q))
      else $error("frequency read differs from last write");
   a_out_hold: assert property (out_valid && !out_ready |=>
      out_valid && $stable(out_word))
      else $error("output word changed while stalled");
   a_reset_quiet: assert property (disable iff (1'b0) rst |=>
      !smp_ready && !out_valid && reg_rdata == 32'h0)
      else $error("outputs active during reset");
   a_raw_sext: assert property (out_valid && out_word.kind == KIND_RAW |->
      out_word.a[19:15] inside {5'h00, 5'h1F} && out_word.b[19:15] inside {5'h00, 5'h1F})
      else $error("raw word not sign extended");
   a_q_after_i: assert property (take && out_word.kind == KIND_Q |-> pair_q)
      else $error("Q word without its I word");
endmodule

// *** test/dnc_sink.sv ***
/*
 model of the output formatter: takes words, stalls one cycle in three, can hold off fully.
 assumes the stream port of dnc_top and one clock.
*/
`timescale 1ns/10ps
module dnc_sink
   import dnc_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // stream from the block
   input wire dnc_word_t out_word,
   input wire logic out_valid,
   output logic out_ready,
   // bench control
   input wire logic hold
);
   dnc_word_t q[$];
   logic [1:0] cnt_q;
   assign out_ready = !hold && cnt_q != 2'h2;
   always @(posedge ref_clk) begin
      if (rst) begin
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= (cnt_q == 2'h2) ? 2'h0 : cnt_q + 2'h1;
         if (out_valid && out_ready) q.push_back(out_word);
      end
   end
endmodule

// *** test/testbench.sv ***
/*
 bench of the down-conversion path: register tasks and mode scenarios on the sample stream.
 assumes dnc_top, dnc_sink and dnc_checker are compiled before it.
*/
`timescale 1ns/10ps
module testbench
   import dnc_pkg::*;
;
   localparam logic [31:0] EN = 32'h1 << CTL_EN;
   localparam logic [31:0] RM = 32'h1 << CTL_REAL;
   localparam logic [31:0] QM = 32'h1 << CTL_QRM;
   localparam logic [31:0] G6 = 32'h1 << CTL_G6;
   localparam logic [31:0] G3 = 32'h1 << CTL_G3;
   localparam logic [31:0] CJ = 32'h1 << CTL_INV;
   localparam logic [31:0] SW = 32'h1 << CTL_SWAP;
   localparam logic [31:0] R20 = 32'h6 << CTL_RES;
   localparam logic [31:0] SY = 32'h1 << CTL_SYNC_EN;
   // a 16-bit sample sits in the top 16 bits of the 20-bit datapath
   localparam logic [41:0] WR = {KIND_REAL, 20'h01000, 20'hFE000};
   localparam logic [41:0] WS = {KIND_REAL, 20'hFE000, 20'h01000};
   localparam logic [41:0] WT = {KIND_REAL, 20'h00040, 20'hFFF80};
   localparam logic [41:0] WG3 = {KIND_REAL, 20'h016A0, 20'hFD2C0};
   localparam logic [41:0] WB0 = {KIND_RAW, 20'h00100, 20'hFFE00};
   localparam logic [41:0] WB1 = {KIND_RAW, 20'h00101, 20'hFFE00};
   localparam logic [41:0] WC = {KIND_I, 20'h00FFE, 20'hFE004};
   localparam logic [41:0] WG6 = {KIND_I, 20'h01FFC, 20'hFC008};
   localparam logic [41:0] WNI = {KIND_I, 20'h007FF, 20'hFF002};
   localparam logic [41:0] WNQ = {KIND_Q, 20'h007FF, 20'hFF002};
   localparam logic [41:0] WJQ = {KIND_Q, 20'hFF801, 20'h00FFE};
   localparam logic [41:0] WQR = {KIND_REAL, 20'h00FFE, 20'hFE004};
   localparam logic [41:0] WQ2 = {KIND_REAL, 20'hFF002, 20'h01FFC};
   localparam logic [41:0] WZ = {KIND_REAL, 40'h0};
   localparam logic [41:0] WQ0 = {KIND_Q, 40'h0};
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic sync_in = 1'b0;
   logic smp_valid = 1'b0;
   logic hold = 1'b0;
   logic rs = 1'b0;
   dnc_pair_t smp_in = 32'h0;
   logic [31:0] reg_rdata;
   logic [31:0] d;
   logic [31:0] rc;
   dnc_word_t out_word;
   logic smp_ready;
   logic out_valid;
   logic out_ready;
   int error_cnt = 0;
   int checks = 0;
   int cyc = 0;
   int taken = 0;

   always #12.5 ref_clk = ~ref_clk;

   dnc_top DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sync_in(sync_in),
      .smp_in(smp_in), .smp_valid(smp_valid), .smp_ready(smp_ready), .out_word(out_word),
      .out_valid(out_valid), .out_ready(out_ready));
   dnc_sink snk (.ref_clk(ref_clk), .rst(rst), .out_word(out_word), .out_valid(out_valid),
      .out_ready(out_ready), .hold(hold));

   task check(input string nm, input logic [41:0] seen, input logic [41:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task tally_and_finish;
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask

   // channel a is 0x0100 (rising by one per sample if inc), channel b is -512
   task feed(input int n, input bit inc);
      int k;
      k = 0;
      smp_in <= {16'h0100, 16'hFE00};
      smp_valid <= 1'b1;
      while (k < n) begin
         @(posedge ref_clk);
         if (smp_ready) begin
            k++;
            smp_in.a <= inc ? 16'h0100 + 16'(k) : 16'h0100;
         end
      end
      smp_valid <= 1'b0;
   endtask

   // reload with a restart toggle, send n samples, compare count and first two words
   task run(input string nm, input logic [31:0] c, input int n, input bit inc, input int cnt,
            input logic [41:0] w0, input logic [41:0] w1);
      rs = ~rs;
      wr(DNC_REG_CTRL, c | {18'h0, rs, 13'h0});
      repeat (4) @(posedge ref_clk);
      snk.q.delete();
      feed(n, inc);
      repeat (60) @(posedge ref_clk);
      check({nm, " count"}, 42'(snk.q.size()), 42'(cnt));
      check({nm, " w0"}, snk.q[0], w0);
      check({nm, " w1"}, snk.q[1], w1);
      $display("test %s done", nm);
   endtask

   always @(posedge ref_clk) begin
      cyc++;
      if (smp_valid && smp_ready) taken++;
      if (cyc == 10000) begin
         error_cnt++;
         tally_and_finish();
      end
   end

   initial begin
      repeat (2) @(posedge ref_clk);
      #1 check("rst valid", 42'(out_valid), 42'h0);
      @(posedge ref_clk);
      rst <= 1'b0;
      rd(DNC_REG_CTRL, d);
      check("ctrl rst", 42'(d), 42'h0);
      wr(DNC_REG_FREQ, 32'h1234_5678);
      wr(DNC_REG_CTRL, 32'hFFFF_DFFF);
      rd(DNC_REG_CTRL, d);
      check("ctrl mask", 42'(d), 42'h0000_5FFF);
      wr(DNC_REG_ACTV, 32'hFFFF_FFFF);
      rd(8'h10, d);
      check("unmapped", 42'(d), 42'h0);
      rd(DNC_REG_ACTV, d);
      check("actv held", 42'(d), 42'h0);
      rs = 1'b1;
      wr(DNC_REG_CTRL, 32'h0000_2000);
      rd(DNC_REG_ACTV, d);
      check("actv load", 42'(d), 42'h1234_5678);
      $display("test registers done");
      wr(DNC_REG_FREQ, 32'h0);
      run("bypass", 32'h0, 4, 1, 4, WB0, WB1);
      snk.q.delete();
      taken = 0;
      hold <= 1'b1;
      smp_valid <= 1'b1;
      repeat (10) @(posedge ref_clk);
      rd(DNC_REG_STAT, d);
      check("stat stall", 42'(d), 42'h0E);
      smp_valid <= 1'b0;
      @(posedge ref_clk);
      hold <= 1'b0;
      #1 check("refuse", 42'(smp_ready), 42'h0);
      repeat (30) @(posedge ref_clk);
      check("no loss", 42'(snk.q.size()), 42'(taken));
      $display("test stall done");
      for (int i = 0; i < 5; i++) begin
         rc = EN | RM | R20 | (32'(i) << CTL_DEC);
         run("real", rc, 64, 0, 64 >> (i + 1), WR, WR);
      end
      run("swap", EN | RM | R20 | SW, 4, 0, 2, WS, WS);
      run("trunc", EN | RM, 4, 0, 2, WT, WT);
      // the 6 dB option must stay off in real mode
      run("g3", EN | RM | R20 | G3 | G6, 4, 0, 2, WG3, WG3);
      run("cplx", EN | R20, 4, 0, 4, WC, WQ0);
      // the 3 dB option must stay off in complex mode
      run("g6", EN | R20 | G6 | G3, 4, 0, 4, WG6, WQ0);
      wr(DNC_REG_FREQ, 32'h4000_0000);
      run("nco", EN | R20, 2, 0, 2, WNI, WNQ);
      run("conj", EN | R20 | CJ, 2, 0, 2, WNI, WJQ);
      // a negative word turns the oscillator the other way
      wr(DNC_REG_FREQ, 32'hC000_0000);
      run("neg", EN | R20, 2, 0, 2, WNI, WJQ);
      wr(DNC_REG_FREQ, 32'h0);
      run("qrm", EN | R20 | QM, 4, 0, 4, WQR, WZ);
      check("qrm w2", snk.q[2], WQ2);
      wr(DNC_REG_FREQ, 32'h0ABC_0000);
      wr(DNC_REG_CTRL, SY | {18'h0, rs, 13'h0});
      rd(DNC_REG_ACTV, d);
      check("sync held", 42'(d), 42'h0);
      @(posedge ref_clk);
      sync_in <= 1'b1;
      repeat (2) @(posedge ref_clk);
      sync_in <= 1'b0;
      rd(DNC_REG_ACTV, d);
      check("sync load", 42'(d), 42'h0ABC_0000);
      $display("test sync done");
      tally_and_finish();
   end
endmodule

bind dnc_top dnc_checker u_chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .sync_in(sync_in), .smp_in(smp_in), .smp_valid(smp_valid), .smp_ready(smp_ready),
   .out_word(out_word), .out_valid(out_valid), .out_ready(out_ready));
